// File: design/vsp_pkg.sv
// package of constants for the display controller two-wire slave port
package vsp_pkg;
	localparam logic [4:0] ADDR_UPPER = 5'h1D;
	localparam logic [6:0] PTR_RESET = 7'h00;
	localparam logic [6:0] PTR_LOW_LAST = 7'h04;
	localparam logic [6:0] PTR_MAP_DATA = 7'h06;
	localparam logic [6:0] PTR_HIGH_FIRST = 7'h07;
	localparam logic [6:0] PTR_HOLD = 7'h7F;
	localparam logic [2:0] BIT_LAST = 3'h7;
	localparam int FIFO_WIDTH = 8;
	localparam int FIFO_DEPTH = 8;
	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_ADDR = 3'b001,
		ST_ADDR_ACK = 3'b011,
		ST_RX = 3'b010,
		ST_RX_ACK = 3'b110,
		ST_TX = 3'b111,
		ST_TX_ACK = 3'b101,
		ST_IGNORE = 3'b100
	} vsp_state_type;
endpackage : vsp_pkg

// File: design/vsp_fifo.sv
// small flip-flop FIFO with valid and ready on both sides
`timescale 1ns/10ps
module vsp_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 8
) (
	input wire logic mclk,
	input wire logic sys_rst,
	input wire logic inValid,
	output logic inReady,
	input wire logic [WIDTH-1:0] inData,
	output logic outValid,
	input wire logic outReady,
	output logic [WIDTH-1:0] outData
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem_reg [DEPTH];
	logic [AW-1:0] wrPtr_reg;
	logic [AW-1:0] rdPtr_reg;
	logic [AW:0] count_reg;
	wire doWrite = inValid && inReady;
	wire doRead = outValid && outReady;
	assign inReady = (count_reg != DEPTH[AW:0]);
	assign outValid = (count_reg != '0);
	assign outData = mem_reg[rdPtr_reg];
	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			wrPtr_reg <= '0;
			rdPtr_reg <= '0;
			count_reg <= '0;
		end else begin
			if (doWrite)
				wrPtr_reg <= wrPtr_reg + 1'b1;
			if (doRead)
				rdPtr_reg <= rdPtr_reg + 1'b1;
			count_reg <= count_reg + {{AW{1'b0}}, doWrite}
				- {{AW{1'b0}}, doRead};
		end
	end
	// storage needs no reset; empty flag guards the reads
	always_ff @(posedge mclk) begin
		if (doWrite)
			mem_reg[wrPtr_reg] <= inData;
	end
endmodule : vsp_fifo

// File: design/vsp_slave_port.sv
// two-wire serial slave port of a display controller
`timescale 1ns/10ps
//
// Contract
// - sda is input and open-drain output; scl is only sampled.
// - transfer is start, address with direction, command, data, stop.
// - start is sda fall with scl high; stop is sda rise.
// - transmitter changes sda only while scl is low.
// - receiver holds sda low in ninth pulse; device acks write bytes.
// - eighth address bit low writes, high reads.
// - address is 11101 then two strap-selected bits.
// - first written byte is stored as command pointer only.
// - first data byte goes to pointer, later ones to advanced pointer.
// - reads use stored pointer and advance it like writes.
// - pointer increments in ranges up to x0000100 and x000111..x1111110.
// - at x0000110 pointer holds, output-map pointer advances.
// - at x1111111 pointer stays fixed.
module vsp_slave_port
	import vsp_pkg::*;
(
	input wire logic mclk,
	input wire logic sys_rst,
	input wire logic sclIn,
	input wire logic sdaIn,
	output logic sdaOut,
	output logic sdaOe,
	input wire logic [1:0] addressStrapPin,
	output logic wrValid,
	input wire logic wrReady,
	output logic [6:0] wrAddr,
	output logic [7:0] wrData,
	output logic [6:0] rdAddr,
	input wire logic [7:0] rdData,
	output logic mapAdvance,
	output logic busBusy
);
	// ------------------------------------------------------------
	// pin synchronisers
	// ------------------------------------------------------------
	logic [1:0] sclSync_reg;
	logic [1:0] sdaSync_reg;
	logic sclLast_reg;
	logic sdaLast_reg;
	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			sclSync_reg <= 2'h3;
			sdaSync_reg <= 2'h3;
			sclLast_reg <= 1'b1;
			sdaLast_reg <= 1'b1;
		end else begin
			sclSync_reg <= {sclSync_reg[0], sclIn};
			sdaSync_reg <= {sdaSync_reg[0], sdaIn};
			sclLast_reg <= sclSync_reg[1];
			sdaLast_reg <= sdaSync_reg[1];
		end
	end
	wire scl = sclSync_reg[1];
	wire sda = sdaSync_reg[1];
	wire sclRise = scl && !sclLast_reg;
	wire sclFall = !scl && sclLast_reg;
	wire startSeen = scl && sclLast_reg && sdaLast_reg && !sda;
	wire stopSeen = scl && sclLast_reg && !sdaLast_reg && sda;

	// ------------------------------------------------------------
	// pointer rules
	// ------------------------------------------------------------
	function automatic logic [6:0] ptrAdvance(input logic [6:0] p);
		if (p == PTR_HOLD)
			return p;
		if (p == PTR_MAP_DATA)
			return p;
		if (p <= PTR_LOW_LAST || p >= PTR_HIGH_FIRST)
			return p + 7'h01;
		return p;
	endfunction : ptrAdvance

	// ------------------------------------------------------------
	// write path buffer
	// ------------------------------------------------------------
	logic pushValid_reg;
	logic [14:0] pushWord_reg;
	logic pushReady;
	logic [14:0] popWord;
	logic popValid;
	vsp_fifo #(.WIDTH(15), .DEPTH(FIFO_DEPTH)) uFifo (
		.mclk(mclk),
		.sys_rst(sys_rst),
		.inValid(pushValid_reg),
		.inReady(pushReady),
		.inData(pushWord_reg),
		.outValid(popValid),
		.outReady(wrReady && !wrValid),
		.outData(popWord)
	);
	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			wrValid <= 1'b0;
			wrAddr <= 7'h00;
			wrData <= 8'h00;
		end else if (wrValid) begin
			wrValid <= 1'b0;
		end else if (popValid && wrReady) begin
			wrValid <= 1'b1;
			wrAddr <= popWord[14:8];
			wrData <= popWord[7:0];
		end
	end

	// ------------------------------------------------------------
	// bit engine decode
	// ------------------------------------------------------------
	vsp_state_type state_reg;
	vsp_state_type state_next;
	logic [2:0] bitCnt_reg;
	logic [2:0] bitCnt_next;
	logic [7:0] shift_reg;
	logic [7:0] shift_next;
	logic [6:0] ptr_reg;
	logic [6:0] ptr_next;
	logic haveCmd_reg;
	logic haveCmd_next;
	logic ackHeld_reg;
	logic ackHeld_next;
	logic masterNack_reg;
	logic masterNack_next;
	logic sdaOe_next;
	logic busBusy_next;
	logic pushValid_next;
	logic [14:0] pushWord_next;
	logic mapAdvance_next;

	wire [6:0] ourAddr = {ADDR_UPPER, addressStrapPin};
	wire [7:0] rxByte = {shift_reg[6:0], sda};
	wire addrMatch = (rxByte[7:1] == ourAddr);
	wire byteDone = sclRise && (bitCnt_reg == BIT_LAST);
	wire txLast = sclFall && (bitCnt_reg == BIT_LAST);
	wire inAck = (state_reg == ST_ADDR_ACK) || (state_reg == ST_RX_ACK);
	// drive low only after scl falls, held through ninth pulse
	wire ackStart = inAck && sclFall && !ackHeld_reg;
	wire ackEnd = inAck && sclFall && ackHeld_reg;
	wire readReq = (state_reg == ST_ADDR_ACK) && shift_reg[0];
	wire cmdPhase = (state_reg == ST_ADDR_ACK) && !shift_reg[0];
	wire [6:0] ptrStep = ptrAdvance(ptr_reg);
	wire atMap = (ptr_reg == PTR_MAP_DATA);

	// ------------------------------------------------------------
	// bit engine next state
	// ------------------------------------------------------------
	always_comb begin
		state_next = state_reg;
		bitCnt_next = bitCnt_reg;
		shift_next = shift_reg;
		ptr_next = ptr_reg;
		haveCmd_next = haveCmd_reg;
		ackHeld_next = ackHeld_reg;
		masterNack_next = masterNack_reg;
		sdaOe_next = sdaOe;
		busBusy_next = busBusy;
		pushValid_next = 1'b0;
		pushWord_next = pushWord_reg;
		mapAdvance_next = 1'b0;
		if (startSeen) begin
			state_next = ST_ADDR;
			bitCnt_next = 3'h0;
			sdaOe_next = 1'b0;
			busBusy_next = 1'b1;
		end else if (stopSeen) begin
			state_next = ST_IDLE;
			sdaOe_next = 1'b0;
			busBusy_next = 1'b0;
		end else begin
			unique case (state_reg)
			ST_IDLE, ST_IGNORE: begin
				sdaOe_next = 1'b0;
			end
			ST_ADDR: begin
				if (sclRise) begin
					shift_next = rxByte;
					bitCnt_next = bitCnt_reg + 3'h1;
				end
				if (byteDone)
					state_next = addrMatch ? ST_ADDR_ACK : ST_IGNORE;
				ackHeld_next = 1'b0;
			end
			ST_ADDR_ACK, ST_RX_ACK: begin
				if (ackStart) begin
					sdaOe_next = 1'b1;
					ackHeld_next = 1'b1;
				end else if (ackEnd) begin
					sdaOe_next = 1'b0;
					ackHeld_next = 1'b0;
					bitCnt_next = 3'h0;
					if (readReq) begin
						state_next = ST_TX;
						shift_next = rdData;
						sdaOe_next = !rdData[7];
					end else begin
						state_next = ST_RX;
					end
					if (cmdPhase)
						haveCmd_next = 1'b0;
				end
			end
			ST_RX: begin
				if (sclRise) begin
					shift_next = rxByte;
					bitCnt_next = bitCnt_reg + 3'h1;
				end
				if (byteDone && !haveCmd_reg) begin
					state_next = ST_RX_ACK;
					ptr_next = rxByte[6:0];
					haveCmd_next = 1'b1;
				end else if (byteDone) begin
					state_next = ST_RX_ACK;
					// full buffer drops the byte rather than stretching scl
					pushValid_next = pushReady;
					pushWord_next = {ptr_reg, rxByte};
					ptr_next = ptrStep;
					mapAdvance_next = atMap;
				end
			end
			ST_TX: begin
				if (sclFall) begin
					bitCnt_next = bitCnt_reg + 3'h1;
					shift_next = {shift_reg[6:0], 1'b0};
					sdaOe_next = !shift_reg[6];
				end
				if (txLast) begin
					state_next = ST_TX_ACK;
					sdaOe_next = 1'b0;
					ptr_next = ptrStep;
					mapAdvance_next = atMap;
				end
			end
			ST_TX_ACK: begin
				if (sclRise)
					masterNack_next = sda;
				if (sclFall) begin
					bitCnt_next = 3'h0;
					if (masterNack_reg) begin
						state_next = ST_IGNORE;
					end else begin
						state_next = ST_TX;
						shift_next = rdData;
						sdaOe_next = !rdData[7];
					end
				end
			end
			endcase
		end
	end

	// ------------------------------------------------------------
	// bit engine registers
	// ------------------------------------------------------------
	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			state_reg <= ST_IDLE;
			bitCnt_reg <= 3'h0;
			shift_reg <= 8'h00;
		end else begin
			state_reg <= state_next;
			bitCnt_reg <= bitCnt_next;
			shift_reg <= shift_next;
		end
	end

	// pointer survives stop so a later read starts where the write left it
	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			ptr_reg <= PTR_RESET;
			haveCmd_reg <= 1'b0;
		end else begin
			ptr_reg <= ptr_next;
			haveCmd_reg <= haveCmd_next;
		end
	end

	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			ackHeld_reg <= 1'b0;
			masterNack_reg <= 1'b0;
		end else begin
			ackHeld_reg <= ackHeld_next;
			masterNack_reg <= masterNack_next;
		end
	end

	// open drain: the data level is always low, only the enable moves
	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			sdaOut <= 1'b0;
			sdaOe <= 1'b0;
			busBusy <= 1'b0;
		end else begin
			sdaOut <= 1'b0;
			sdaOe <= sdaOe_next;
			busBusy <= busBusy_next;
		end
	end

	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			pushValid_reg <= 1'b0;
			pushWord_reg <= 15'h0000;
		end else begin
			pushValid_reg <= pushValid_next;
			pushWord_reg <= pushWord_next;
		end
	end

	// read address lags the pointer a cycle; read data is taken much later
	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			rdAddr <= PTR_RESET;
			mapAdvance <= 1'b0;
		end else begin
			rdAddr <= ptr_reg;
			mapAdvance <= mapAdvance_next;
		end
	end
endmodule : vsp_slave_port

// File: bench/vsp_slave_port_properties.sv
// pin-level checks on the two-wire slave port
`timescale 1ns/10ps
module vsp_slave_port_properties (
	input wire logic mclk,
	input wire logic sys_rst,
	input wire logic sclIn,
	input wire logic sdaIn,
	input wire logic sdaOut,
	input wire logic sdaOe,
	input wire logic [1:0] addressStrapPin,
	input wire logic wrValid,
	input wire logic wrReady,
	input wire logic [6:0] wrAddr,
	input wire logic [7:0] wrData,
	input wire logic [6:0] rdAddr,
	input wire logic [7:0] rdData,
	input wire logic mapAdvance,
	input wire logic busBusy
);
	// ----
	// checks
	// ----
	default clocking @(posedge mclk); endclocking
	default disable iff (sys_rst);
	property p_drv; sdaOut == 1'b0; endproperty
	a_drv: assert property (p_drv) else $error("sda driven high");
	property p_idle; !busBusy |-> !sdaOe; endproperty
	a_idle: assert property (p_idle) else $error("pull when idle");
	property p_start; $fell(sdaIn) && sclIn |-> ##[1:6] busBusy; endproperty
	a_start: assert property (p_start) else $error("start missed");
	property p_stop; $rose(sdaIn) && sclIn |-> ##[1:6] !busBusy; endproperty
	a_stop: assert property (p_stop) else $error("stop missed");
	// sync lag leaves little margin: changes must land in the low phase
	property p_oe; $changed(sdaOe) |-> !sclIn; endproperty
	a_oe: assert property (p_oe) else $error("sda moved, scl high");
	property p_wr; wrValid |=> !wrValid; endproperty
	a_wr: assert property (p_wr) else $error("write too long");
	property p_map; mapAdvance |-> rdAddr == 7'h06 ##1 !mapAdvance; endproperty
	a_map: assert property (p_map) else $error("map step");
	property p_keep; !busBusy && !$past(busBusy) |-> $stable(rdAddr); endproperty
	a_keep: assert property (p_keep) else $error("pointer moved");
endmodule : vsp_slave_port_properties

// File: bench/vsp_bus_master.sv
// bus master model on the far side of the port
`timescale 1ns/10ps
module vsp_bus_master (
	output logic scl,
	output logic sdaLow,
	input wire logic sda
);
	// ----
	// frame tasks
	// ----
	// scl rests high between frames; released sda goes to the pull-up
	initial begin
		scl = 1'b1;
		sdaLow = 1'b0;
	end
	task automatic bitx(input logic b, output logic s);
		#100 sdaLow = !b;
		#100 scl = 1'b1;
		#100 s = sda;
		#100 scl = 1'b0;
	endtask : bitx
	task automatic start;
		if (!scl) begin
			#100 sdaLow = 1'b0;
			#100 scl = 1'b1;
		end
		#100 sdaLow = 1'b1;
		#100 scl = 1'b0;
	endtask : start
	task automatic stop;
		#100 sdaLow = 1'b1;
		#100 scl = 1'b1;
		#100 sdaLow = 1'b0;
		#200;
	endtask : stop
	task automatic sendByte(input logic [7:0] d, output logic a);
		logic s;
		for (int i = 7; i >= 0; i--) bitx(d[i], s);
		bitx(1'b1, a);
	endtask : sendByte
	task automatic getByte(input logic ack, output logic [7:0] d);
		logic s;
		for (int i = 7; i >= 0; i--) bitx(1'b1, d[i]);
		bitx(!ack, s);
	endtask : getByte
endmodule : vsp_bus_master

// File: bench/vsp_slave_port_tb_top.sv
// self-checking bench for the two-wire slave port
`timescale 1ns/10ps
module vsp_slave_port_tb_top import vsp_pkg::*; ;
	logic mclk, sys_rst, sdaLow, sclIn, wrReady, sdaOut, sdaOe, wrValid;
	logic mapAdvance, busBusy;
	logic [1:0] addressStrapPin;
	logic [6:0] wrAddr, rdAddr;
	logic [7:0] wrData, rdData;
	logic [14:0] expQ[$];
	int failures, cmp_count, mapCnt, seed = 88688;
	wire sdaIn = !(sdaLow | (sdaOe & !sdaOut));
	assign rdData = {1'b1, rdAddr} ^ 8'h3C;
	vsp_slave_port i_vsp_slave_port (.mclk, .sys_rst, .sclIn, .sdaIn,
		.sdaOut, .sdaOe, .addressStrapPin, .wrValid, .wrReady, .wrAddr,
		.wrData, .rdAddr, .rdData, .mapAdvance, .busBusy);
	vsp_bus_master bm (.scl(sclIn), .sdaLow, .sda(sdaIn));
	// ----
	// helpers
	// ----
	initial begin
		mclk = 1'b0;
		forever #25 mclk = !mclk;
	end
	function automatic logic [6:0] nxt(input logic [6:0] p);
		return (p <= 7'h04 || (p >= 7'h07 && p != 7'h7F)) ? p + 7'h01 : p;
	endfunction : nxt
	task automatic chk(input logic [15:0] s, input logic [15:0] e);
		cmp_count++;
		if (s !== e) begin
			failures++;
			$display("ERROR %0t seen %h want %h", $time, s, e);
		end
	endtask : chk
	task automatic test_done;
		if (failures == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask : test_done
	task automatic cmd(input logic [1:0] st, input logic [6:0] p,
		output logic a);
		logic a1;
		bm.start();
		bm.sendByte({5'h1D, st, 1'b0}, a1);
		bm.sendByte({1'b0, p}, a);
		a = a | a1;
	endtask : cmd
	task automatic wr(input logic [6:0] p, input int n, input logic bad);
		logic [7:0] d;
		logic a;
		cmd(addressStrapPin ^ {bad, bad}, p, a);
		chk(a, bad);
		repeat (n) begin
			d = 8'($random(seed));
			if (!bad) expQ.push_back({p, d});
			p = nxt(p);
			bm.sendByte(d, a);
			chk(a, bad);
		end
		bm.stop();
		for (int k = 0; k < 300 && expQ.size() > 0; k++) @(posedge mclk);
		chk(16'(expQ.size()), 16'h0000);
		@(posedge mclk);
		#3;
	endtask : wr
	task automatic rd(input logic [6:0] p, input int n);
		logic [7:0] d;
		logic a;
		cmd(addressStrapPin, p, a);
		chk(a, 1'b0);
		bm.start();
		bm.sendByte({5'h1D, addressStrapPin, 1'b1}, a);
		chk(a, 1'b0);
		for (int k = 1; k <= n; k++) begin
			bm.getByte(k < n, d);
			chk(d, {1'b1, p} ^ 8'h3C);
			p = nxt(p);
		end
		bm.stop();
	endtask : rd
	// random ready makes the fifo drain at an uneven pace
	always @(posedge mclk) begin
		wrReady <= #3 1'($random(seed));
		if (mapAdvance === 1'b1) mapCnt++;
		if (wrValid === 1'b1) begin
			chk({1'b0, wrAddr, wrData}, {1'b0, expQ[0]});
			void'(expQ.pop_front());
		end
	end
	initial begin
		sys_rst = 1'b1;
		wrReady = 1'b1;
		addressStrapPin = 2'b00;
		repeat (12) @(posedge mclk);
		#3 sys_rst = 1'b0;
		repeat (4) @(posedge mclk);
		#3;
		wr(7'h03, 4, 1'b0);
		mapCnt = 0;
		wr(7'h06, 2, 1'b0);
		chk(16'(mapCnt), 16'h0002);
		wr(7'h7E, 3, 1'b0);
		wr(7'h44, 2, 1'b1);
		rd(7'h7F, 2);
		rd(7'h1F, 3);
		for (int s = 0; s < 4; s++) begin
			addressStrapPin = 2'(s);
			wr(7'($random(seed) & 7'h6F), 2, 1'b0);
			rd(7'h7C + 7'(s), 2);
		end
		test_done();
	end
	initial begin
		#3000000;
		failures++;
		test_done();
	end
endmodule : vsp_slave_port_tb_top
bind vsp_slave_port vsp_slave_port_properties i_chk (.mclk, .sys_rst,
	.sclIn, .sdaIn, .sdaOut, .sdaOe, .addressStrapPin, .wrValid, .wrReady,
	.wrAddr, .wrData, .rdAddr, .rdData, .mapAdvance, .busBusy);
